// *** fault_pkg.sv ***
package fault_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index
  localparam logic [7:0] BOOST_IDX   = 8'h10;
  localparam logic [7:0] LED_IDX     = 8'h12;
  localparam logic [7:0] INT_EN_IDX  = 8'h20;
  localparam int         ADDR_W      = 10;
  localparam int         DATA_W      = 32;
  localparam int         REG_W       = 16;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  // Boost register: eight status/clear pairs, status above clear
  localparam int         BOOST_PAIRS = 8;
  localparam int         THERMAL_BIT = 15;
  localparam int         CURRES_BIT  = 13;
  localparam int         STRRES_BIT  = 11;
  localparam int         MODERES_BIT = 9;
  localparam int         FREQRES_BIT = 7;
  localparam int         OCP_BIT     = 5;
  localparam int         OVPH_BIT    = 3;
  localparam int         OVPL_BIT    = 1;
  // Fault register of the LED side
  localparam int         RSVD_BIT    = 15;
  localparam int         TIMEOUT_BIT = 14;
  localparam int         TIMEOUT_CLR = 13;
  localparam int         BADSTR_BIT  = 12;
  localparam int         BADSTR_CLR  = 11;
  localparam int         ANYLED_BIT  = 10;
  localparam int         ANYLED_CLR  = 9;
  localparam int         GND_BIT     = 8;
  localparam int         SHORT_BIT   = 7;
  localparam int         OPEN_BIT    = 6;
  localparam int         CHAN_LSB    = 0;
  localparam int         CHANNELS    = 6;
  // Interrupt enable register: three two-bit fields
  localparam int         EN_TIMEOUT_LSB = 4;
  localparam int         EN_BADSTR_LSB  = 2;
  localparam int         EN_ANYLED_LSB  = 0;

  // ----------------------------------------------------------------
  // Codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  EN_READ_OFF  = 2'h0;
  localparam logic [1:0]  EN_READ_ON   = 2'h2;
  localparam logic [1:0]  EN_WR_OFF    = 2'h1;
  localparam logic [1:0]  EN_WR_ON     = 2'h3;
  localparam logic        EN_RESET     = 1'b1;
  localparam logic [15:0] FLAGS_RESET  = 16'h0000;
  localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

  // Fault input vector width
  localparam int          EVENTS       = 19;

endpackage : fault_pkg

// *** boost_led_fault_status.sv ***
`timescale 1ns/1ps
module boost_led_fault_status (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic [fault_pkg::ADDR_W-1:0] address,
  input  wire logic                        read,
  input  wire logic                        write,
  input  wire logic [3:0]                  byteenable,
  input  wire logic [fault_pkg::DATA_W-1:0] writedata,
  output logic      [fault_pkg::DATA_W-1:0] readdata,
  output logic                             waitrequest,
  input  wire logic [7:0]                  boost_fault_in,
  input  wire logic                        bus_timeout_in,
  input  wire logic                        bad_string_in,
  input  wire logic                        channel_ground_short,
  input  wire logic                        channel_internal_short,
  input  wire logic                        channel_open,
  input  wire logic [5:0]                  chan_fault_in,
  output logic                             fault_pin
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // True when both bits of a status/clear pair are written as one
  function automatic logic pair_clear(input logic [15:0] wd, input int sbit);
    pair_clear = wd[sbit] & wd[sbit-1];
  endfunction : pair_clear

  // Next value of a two-bit enable field from a write code
  function automatic logic en_update(input logic cur, input logic [1:0] code);
    case (code)
      fault_pkg::EN_WR_OFF: en_update = 1'b0;
      fault_pkg::EN_WR_ON:  en_update = 1'b1;
      default:              en_update = cur;
    endcase
  endfunction : en_update

  // True when a byte address selects the word of one register index
  function automatic logic reg_hit(input logic [fault_pkg::ADDR_W-1:0] addr,
                                   input logic [7:0]                   idx);
    reg_hit = addr == {idx, 2'b00};
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [fault_pkg::EVENTS-1:0] ev_raw;
  logic [fault_pkg::EVENTS-1:0] ev_s1_q;
  logic [fault_pkg::EVENTS-1:0] ev_s2_q;
  logic [fault_pkg::EVENTS-1:0] ev_s3_q;
  logic [fault_pkg::EVENTS-1:0] ev_q;

  assign ev_raw = {boost_fault_in, bus_timeout_in, bad_string_in, channel_ground_short,
                   channel_internal_short, channel_open, chan_fault_in};

  // Three-stage chain on every fault pin
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
    end
    else
    begin
      ev_s1_q <= ev_raw;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  // Accept a level only once stages two and three agree
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      ev_q <= '0;
    else
      for (int i = 0; i < fault_pkg::EVENTS; i++)
        if (ev_s2_q[i] == ev_s3_q[i])
          ev_q[i] <= ev_s2_q[i];
  end

  // Unpack the filtered fault levels
  logic [7:0] boost_ev;
  logic       timeout_ev;
  logic       badstr_ev;
  logic       gnd_ev;
  logic       short_ev;
  logic       open_ev;
  logic [5:0] chan_ev;

  assign {boost_ev, timeout_ev, badstr_ev, gnd_ev, short_ev, open_ev, chan_ev} = ev_q;

  // ----------------------------------------------------------------
  // Avalon-MM slave handshake
  // ----------------------------------------------------------------
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        wr_go;
  logic        hit_boost;
  logic        hit_led;
  logic        hit_en;
  logic [15:0] wd;

  // Word decode on byte addresses, four per index
  assign hit_boost = reg_hit(address, fault_pkg::BOOST_IDX);
  assign hit_led   = reg_hit(address, fault_pkg::LED_IDX);
  assign hit_en    = reg_hit(address, fault_pkg::INT_EN_IDX);
  // Write takes effect on the edge where waitrequest is low
  assign wr_go     = write & ~wait_q;
  // Lanes disabled by byteenable are seen as zero
  assign wd        = writedata[15:0] & {{8{byteenable[1]}}, {8{byteenable[0]}}};

  // One wait state, then a single low cycle of waitrequest
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      wait_q <= 1'b1;
    else if ((read | write) & wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Boost fault flags
  // ----------------------------------------------------------------
  // Index 7 thermal down to 0 over-voltage low, same order as the pins
  logic [7:0] boost_q;
  logic [7:0] boost_clr;
  logic       boost_wr;

  // A boost register write that completes in this cycle
  assign boost_wr = wr_go & hit_boost;

  // Pair clears from a write to the boost register; each fault has its own pair
  always_comb
  begin
    boost_clr = '0;
    if (boost_wr)
    begin
      boost_clr[7] = pair_clear(wd, fault_pkg::THERMAL_BIT);
      boost_clr[6] = pair_clear(wd, fault_pkg::CURRES_BIT);
      boost_clr[5] = pair_clear(wd, fault_pkg::STRRES_BIT);
      boost_clr[4] = pair_clear(wd, fault_pkg::MODERES_BIT);
      boost_clr[3] = pair_clear(wd, fault_pkg::FREQRES_BIT);
      boost_clr[2] = pair_clear(wd, fault_pkg::OCP_BIT);
      boost_clr[1] = pair_clear(wd, fault_pkg::OVPH_BIT);
      boost_clr[0] = pair_clear(wd, fault_pkg::OVPL_BIT);
    end
  end

  // Latch on fault, clear on full pair; a live fault wins over the clear
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      boost_q <= fault_pkg::FLAGS_RESET[7:0];
    else
      boost_q <= boost_ev | (boost_q & ~boost_clr);
  end

  // ----------------------------------------------------------------
  // LED side fault flags
  // ----------------------------------------------------------------
  logic       timeout_q;
  logic       badstr_q;
  logic       anyled_q;
  logic       gnd_q;
  logic       short_q;
  logic       open_q;
  logic [5:0] chan_q;
  logic       timeout_clr;
  logic       badstr_clr;
  logic       anyled_clr;

  assign timeout_clr = wr_go & hit_led & pair_clear(wd, fault_pkg::TIMEOUT_BIT);
  assign badstr_clr  = wr_go & hit_led & pair_clear(wd, fault_pkg::BADSTR_BIT);
  assign anyled_clr  = wr_go & hit_led & pair_clear(wd, fault_pkg::ANYLED_BIT);

  // Bus timeout and string setup flags
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      timeout_q <= 1'b0;
      badstr_q  <= 1'b0;
    end
    else
    begin
      timeout_q <= timeout_ev | (timeout_q & ~timeout_clr);
      badstr_q  <= badstr_ev | (badstr_q & ~badstr_clr);
    end
  end

  // Aggregate flag and its read-only detail flags share one clear
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      anyled_q <= 1'b0;
      gnd_q    <= 1'b0;
      short_q  <= 1'b0;
      open_q   <= 1'b0;
      chan_q   <= '0;
    end
    else
    begin
      anyled_q <= (gnd_ev | short_ev | open_ev) | (anyled_q & ~anyled_clr);
      gnd_q    <= gnd_ev | (gnd_q & ~anyled_clr);
      short_q  <= short_ev | (short_q & ~anyled_clr);
      open_q   <= open_ev | (open_q & ~anyled_clr);
      chan_q   <= chan_ev | (chan_q & ~{6{anyled_clr}});
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------
  logic en_timeout_q;
  logic en_badstr_q;
  logic en_anyled_q;

  // Only codes 1h and 3h change a field
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      en_timeout_q <= fault_pkg::EN_RESET;
      en_badstr_q  <= fault_pkg::EN_RESET;
      en_anyled_q  <= fault_pkg::EN_RESET;
    end
    else if (wr_go & hit_en)
    begin
      en_timeout_q <= en_update(en_timeout_q, wd[fault_pkg::EN_TIMEOUT_LSB +: 2]);
      en_badstr_q  <= en_update(en_badstr_q, wd[fault_pkg::EN_BADSTR_LSB +: 2]);
      en_anyled_q  <= en_update(en_anyled_q, wd[fault_pkg::EN_ANYLED_LSB +: 2]);
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] boost_rd;
  logic [15:0] led_rd;
  logic [15:0] en_rd;

  // Status bits show flags, clear bits and the reserved bit read zero
  always_comb
  begin
    boost_rd = '0;
    boost_rd[fault_pkg::THERMAL_BIT] = boost_q[7];
    boost_rd[fault_pkg::CURRES_BIT]  = boost_q[6];
    boost_rd[fault_pkg::STRRES_BIT]  = boost_q[5];
    boost_rd[fault_pkg::MODERES_BIT] = boost_q[4];
    boost_rd[fault_pkg::FREQRES_BIT] = boost_q[3];
    boost_rd[fault_pkg::OCP_BIT]     = boost_q[2];
    boost_rd[fault_pkg::OVPH_BIT]    = boost_q[1];
    boost_rd[fault_pkg::OVPL_BIT]    = boost_q[0];
    led_rd = '0;
    led_rd[fault_pkg::RSVD_BIT]      = 1'b0;
    led_rd[fault_pkg::TIMEOUT_BIT]   = timeout_q;
    led_rd[fault_pkg::BADSTR_BIT]    = badstr_q;
    led_rd[fault_pkg::ANYLED_BIT]    = anyled_q;
    led_rd[fault_pkg::GND_BIT]       = gnd_q;
    led_rd[fault_pkg::SHORT_BIT]     = short_q;
    led_rd[fault_pkg::OPEN_BIT]      = open_q;
    led_rd[fault_pkg::CHAN_LSB +: fault_pkg::CHANNELS] = chan_q;
    en_rd = '0;
    en_rd[fault_pkg::EN_TIMEOUT_LSB +: 2] = en_timeout_q ? fault_pkg::EN_READ_ON
                                                         : fault_pkg::EN_READ_OFF;
    en_rd[fault_pkg::EN_BADSTR_LSB +: 2]  = en_badstr_q ? fault_pkg::EN_READ_ON
                                                        : fault_pkg::EN_READ_OFF;
    en_rd[fault_pkg::EN_ANYLED_LSB +: 2]  = en_anyled_q ? fault_pkg::EN_READ_ON
                                                        : fault_pkg::EN_READ_OFF;
  end

  // Read word captured as waitrequest drops; unmapped reads give zero
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rdata_q <= fault_pkg::UNMAPPED_RD;
    else if (read & wait_q)
    begin
      if (hit_boost)
        rdata_q <= {16'h0000, boost_rd};
      else if (hit_led)
        rdata_q <= {16'h0000, led_rd};
      else if (hit_en)
        rdata_q <= {16'h0000, en_rd};
      else
        rdata_q <= fault_pkg::UNMAPPED_RD;
    end
  end

  // ----------------------------------------------------------------
  // Fault pin
  // ----------------------------------------------------------------
  logic pin_q;
  logic boost_cause;
  logic led_cause;

  // Boost flags always reach the pin; LED side flags pass their enables
  assign boost_cause = |boost_q;
  assign led_cause   = (timeout_q & en_timeout_q) | (badstr_q & en_badstr_q)
                       | (anyled_q & en_anyled_q);

  // Pin follows the flags one cycle later, so a pair clear releases it too
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      pin_q <= 1'b0;
    else
      pin_q <= boost_cause | led_cause;
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;
  assign fault_pin   = pin_q;

endmodule : boost_led_fault_status

// *** fault_chk.sv ***
`timescale 1ns/1ps
module fault_chk (
  input wire logic                          clock,
  input wire logic                          reset,
  input wire logic [fault_pkg::ADDR_W-1:0]  address,
  input wire logic                          read,
  input wire logic                          write,
  input wire logic [fault_pkg::DATA_W-1:0]  readdata,
  input wire logic                          waitrequest,
  input wire logic [7:0]                    boost_fault_in,
  input wire logic                          bus_timeout_in,
  input wire logic                          bad_string_in,
  input wire logic                          channel_ground_short,
  input wire logic                          channel_internal_short,
  input wire logic                          channel_open,
  input wire logic [5:0]                    chan_fault_in,
  input wire logic                          fault_pin
);
  logic any_in;
  logic rd_done;
  logic wr_done;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // Fault activity and bus completions
  assign any_in  = (|boost_fault_in) | bus_timeout_in | bad_string_in | channel_ground_short
                   | channel_internal_short | channel_open | (|chan_fault_in);
  assign rd_done = read && !waitrequest;
  assign wr_done = write && !waitrequest;

  property p_wait_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low over one cycle");
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_pin_boost;
    (|boost_fault_in) [*7] |-> fault_pin;
  endproperty
  a_pin_boost: assert property (p_pin_boost) else $error("boost fault not on pin");
  property p_pin_cause;
    $rose(fault_pin) |-> $past(any_in, 3) || $past(any_in, 4) || $past(any_in, 5)
                         || $past(any_in, 6) || $past(wr_done, 2);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin rose without cause");
  property p_upper;
    rd_done |-> readdata[31:16] == 16'h0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read half not zero");
  property p_unmapped;
    rd_done && !(address inside {10'h040, 10'h048, 10'h080}) |-> readdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rsvd;
    rd_done && address == 10'h048 |-> !readdata[15];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_en_codes;
    rd_done && address == 10'h080 |-> !readdata[0] && !readdata[2] && !readdata[4];
  endproperty
  a_en_codes: assert property (p_en_codes) else $error("enable field odd code");
  property p_aggr;
    rd_done && address == 10'h048 && (|readdata[8:6]) |-> readdata[10];
  endproperty
  a_aggr: assert property (p_aggr) else $error("detail flag without aggregate");

  c_wr: cover property (wr_done && address == 10'h040);
  c_pin: cover property ($rose(fault_pin));
  c_en: cover property (rd_done && address == 10'h080);
endmodule : fault_chk

bind boost_led_fault_status fault_chk chk_u (
  .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .boost_fault_in(boost_fault_in),
  .bus_timeout_in(bus_timeout_in), .bad_string_in(bad_string_in),
  .channel_ground_short(channel_ground_short), .channel_internal_short(channel_internal_short),
  .channel_open(channel_open), .chan_fault_in(chan_fault_in), .fault_pin(fault_pin)
);

// *** boost_led_fault_status_tb.sv ***
`timescale 1ns/1ps
module boost_led_fault_status_tb;
  logic        clock, reset, read, write, waitrequest, fault_pin;
  logic        bus_timeout_in, bad_string_in, channel_ground_short;
  logic        channel_internal_short, channel_open;
  logic [9:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, d;
  logic [7:0]  boost_fault_in;
  logic [5:0]  chan_fault_in;
  int          err_count, checks_done;
  logic [15:0] bst [8] = '{16'h0002, 16'h0008, 16'h0020, 16'h0080, 16'h0200, 16'h0800,
                           16'h2000, 16'h8000};
  logic [10:0] led_in [6] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h061};
  logic [15:0] led_e [6] = '{16'h4000, 16'h1000, 16'h0500, 16'h0480, 16'h0440, 16'h0461};

  boost_led_fault_status dut_u (
    .clock(clock), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .boost_fault_in(boost_fault_in),
    .bus_timeout_in(bus_timeout_in), .bad_string_in(bad_string_in),
    .channel_ground_short(channel_ground_short),
    .channel_internal_short(channel_internal_short), .channel_open(channel_open),
    .chan_fault_in(chan_fault_in), .fault_pin(fault_pin)
  );

  // Clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task summarize;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  task chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Hold request until waitrequest is sampled low
  task wait_ack;
    int n;
    n = 0;
    @(posedge clock);
    while (waitrequest !== 1'b0 && n < 50)
    begin
      n++;
      @(posedge clock);
    end
    if (waitrequest !== 1'b0)
    begin
      err_count++;
      summarize();
    end
  endtask : wait_ack

  task wr(input logic [9:0] a, input logic [15:0] v);
    address   <= a;
    writedata <= {16'h0000, v};
    write     <= 1'b1;
    wait_ack();
    write <= 1'b0;
    @(posedge clock);
  endtask : wr

  task rc(input logic [9:0] a, input logic [15:0] e);
    address <= a;
    read    <= 1'b1;
    wait_ack();
    d = readdata;
    read <= 1'b0;
    @(posedge clock);
    chk(d[15:0], e);
  endtask : rc

  task settle;
    repeat (8) @(posedge clock);
  endtask : settle

  // Latched flag, half-pair writes, full-pair clear
  task fc(input logic [9:0] a, input logic [15:0] e);
    rc(a, e);
    chk({15'h0000, fault_pin}, 16'h0001);
    wr(a, e);
    rc(a, e);
    wr(a, e >> 1);
    rc(a, e);
    wr(a, e | (e >> 1));
    rc(a, 16'h0000);
    settle();
    chk({15'h0000, fault_pin}, 16'h0000);
  endtask : fc

  // Main sequence
  initial
  begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = 10'h000; byteenable = 4'hF;
    writedata = 32'h0000_0000; boost_fault_in = 8'h00; chan_fault_in = 6'h00;
    bus_timeout_in = 1'b0; bad_string_in = 1'b0; channel_ground_short = 1'b0;
    channel_internal_short = 1'b0; channel_open = 1'b0;
    err_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rc(10'h040, 16'h0000);
    rc(10'h048, 16'h0000);
    rc(10'h080, 16'h002A);
    wr(10'h3FC, 16'hFFFF);
    rc(10'h3FC, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      boost_fault_in <= 8'(1 << i);
      settle();
      boost_fault_in <= 8'h00;
      settle();
      fc(10'h040, bst[i]);
    end
    for (int j = 0; j < 6; j++)
    begin
      {bus_timeout_in, bad_string_in, channel_ground_short, channel_internal_short,
       channel_open, chan_fault_in} <= led_in[j];
      settle();
      {bus_timeout_in, bad_string_in, channel_ground_short, channel_internal_short,
       channel_open, chan_fault_in} <= 11'h000;
      settle();
      fc(10'h048, led_e[j]);
    end
    // Interrupt enable codes; a masked low lane writes nothing
    byteenable <= 4'h2;
    wr(10'h080, 16'h0001);
    byteenable <= 4'hF;
    rc(10'h080, 16'h002A);
    wr(10'h080, 16'h0001);
    rc(10'h080, 16'h0028);
    wr(10'h080, 16'h0000);
    rc(10'h080, 16'h0028);
    channel_open <= 1'b1;
    settle();
    channel_open <= 1'b0;
    settle();
    rc(10'h048, 16'h0440);
    chk({15'h0000, fault_pin}, 16'h0000);
    wr(10'h080, 16'h0003);
    settle();
    chk({15'h0000, fault_pin}, 16'h0001);
    rc(10'h080, 16'h002A);
    wr(10'h048, 16'h0600);
    settle();
    chk({15'h0000, fault_pin}, 16'h0000);
    summarize();
  end
endmodule : boost_led_fault_status_tb
